/* File: gpio_level_pkg.sv */
// constants for the pin level and status register block
package gpio_level_pkg;
    localparam int NUM_PINS = 13;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] PIN_STATUS_OFFSET = 8'hE6;
    localparam int UNUSED_LSB = 13;
    localparam logic [2:0] UNUSED_VALUE = 3'h7;
    localparam logic [12:0] LEVEL_RESET = 13'h0000;
    localparam logic [12:0] NO_DRIVE = 13'h1FFF;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;
    localparam logic [15:0] READ_RESET = {UNUSED_VALUE, LEVEL_RESET};
endpackage

/* File: gpio_pin_level_register.sv */
// pin level and status register for thirteen general-purpose pins
// What this block does
// - One level bit per pin: status bit n is pin n, pins 0-12.
// - Input pin: reading its bit returns the sampled pin level.
// - Input pin: writing zero clears only that pin's event flag.
// - Output pin: writing its bit sets the value driven on the pin.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_level_register (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control interface register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // per-pin direction from the pin configuration, 1 = output
    input wire logic [12:0] pin_dir_i,
    // event pulses from the pin edge detection logic
    input wire logic [12:0] event_set_i,
    output logic [12:0] event_flag_o,
    // pin pads
    input wire logic [12:0] pin_in_i,
    output logic [12:0] pin_out_o,
    output logic [12:0] pin_oe_n_o
);
    logic [12:0] sync_level;
    logic [12:0] out_latch;
    logic [12:0] flag;
    logic [12:0] oe_n;
    logic [15:0] rdata;

    wire addr_hit;
    wire wr_hit;
    wire rd_hit;
    wire [12:0] in_mask;
    wire [12:0] clear_mask;
    wire [12:0] next_out_latch;
    wire [12:0] next_flag;
    wire [12:0] level_view;
    wire [15:0] read_view;
    wire [15:0] next_rdata;

    // pad levels cross into the clock domain
    pin_sync #(
        .WIDTH(gpio_level_pkg::NUM_PINS)
    ) u_pin_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .async_i(pin_in_i),
        .sync_o(sync_level)
    );

    // address decode for the single mapped register
    assign addr_hit = (reg_addr_i == gpio_level_pkg::PIN_STATUS_OFFSET);
    assign wr_hit = reg_wr_i & addr_hit;
    assign rd_hit = reg_rd_i & addr_hit;
    assign in_mask = ~pin_dir_i;

    // writes land in the output latch only for output pins
    assign next_out_latch = wr_hit ? ((out_latch & in_mask) | (reg_wdata_i[12:0] & pin_dir_i))
                                   : out_latch;

    // a written zero on an input pin clears its own flag
    assign clear_mask = wr_hit ? (~reg_wdata_i[12:0] & in_mask) : 13'h0000;

    // a new event wins over a clear in the same cycle
    assign next_flag = event_set_i | (flag & ~clear_mask);

    // bit n shows pin n: sampled level for inputs, driven value for outputs
    assign level_view = (sync_level & in_mask) | (out_latch & pin_dir_i);

    // unused top bits are constant ones, untouched by writes or reset
    assign read_view = {gpio_level_pkg::UNUSED_VALUE, level_view};

    // read data is captured on a read, held otherwise
    assign next_rdata = !reg_rd_i ? rdata :
                        (addr_hit ? read_view : gpio_level_pkg::UNMAPPED_READ);

    // level, flag and drive state
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            out_latch <= gpio_level_pkg::LEVEL_RESET;
            flag <= gpio_level_pkg::LEVEL_RESET;
            oe_n <= gpio_level_pkg::NO_DRIVE;
        end
        else
        begin
            out_latch <= next_out_latch;
            flag <= next_flag;
            oe_n <= in_mask;
        end
    end

    // read data register
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            rdata <= gpio_level_pkg::READ_RESET;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata_o = rdata;
    assign event_flag_o = flag;
    assign pin_out_o = out_latch;
    assign pin_oe_n_o = oe_n;

    // checks on the register behaviour
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    // pins held still long enough to pass the synchroniser
    sequence pins_quiet;
        (pin_in_i == $past(pin_in_i)) [*3];
    endsequence

    // a read request taken on the mapped address
    sequence status_read;
        rd_hit;
    endsequence

    // a write to the mapped address with no new events arriving
    sequence clean_write;
        wr_hit && (event_set_i == 13'h0000);
    endsequence

    // a cycle with no read request
    sequence no_read;
        !reg_rd_i;
    endsequence

    // a cycle with no mapped write and no new event
    sequence quiet_cycle;
        !wr_hit && (event_set_i == 13'h0000);
    endsequence

    // a write that misses the mapped address
    sequence stray_write;
        reg_wr_i && !addr_hit;
    endsequence

    // a write, an idle cycle, then a read, direction unchanged throughout
    sequence write_idle_read;
        wr_hit ##1 (!wr_hit && $stable(pin_dir_i)) ##1 (rd_hit && $stable(pin_dir_i));
    endsequence

    a_input_level_read: assert property (
        (pins_quiet ##0 status_read) |=>
            ((reg_rdata_o[12:0] & ~$past(pin_dir_i)) == ($past(pin_in_i) & ~$past(pin_dir_i))))
    else $error("input pin read does not show the pin level");

    a_output_level_read: assert property (
        status_read |=>
            ((reg_rdata_o[12:0] & $past(pin_dir_i)) == ($past(pin_out_o) & $past(pin_dir_i))))
    else $error("output pin read does not show the driven value");

    a_unused_bits_one: assert property (
        status_read |=> (reg_rdata_o[15:13] == 3'h7))
    else $error("unused status bits did not read as one");

    a_unmapped_read_zero: assert property (
        (reg_rd_i && !addr_hit) |=> (reg_rdata_o == 16'h0000))
    else $error("unmapped read returned nonzero data");

    a_flag_write_clear: assert property (
        clean_write |=> ((event_flag_o & $past(~reg_wdata_i[12:0] & ~pin_dir_i)) == 13'h0000))
    else $error("written zero did not clear the input pin flag");

    a_flag_others_kept: assert property (
        wr_hit |=> ((event_flag_o & $past(event_flag_o & (reg_wdata_i[12:0] | pin_dir_i)))
                    == $past(event_flag_o & (reg_wdata_i[12:0] | pin_dir_i))))
    else $error("flag of another pin changed on a write");

    a_flag_set_wins: assert property (
        (event_set_i != 13'h0000) |=>
            ((event_flag_o & $past(event_set_i)) == $past(event_set_i)))
    else $error("event was lost against a clear");

    a_pin_drive_value: assert property (
        wr_hit |=> (((pin_out_o & $past(pin_dir_i)) == ($past(reg_wdata_i[12:0]) & $past(pin_dir_i)))
                    && (pin_oe_n_o == ~$past(pin_dir_i))))
    else $error("output pin not driven with the written value");

    a_input_drive_kept: assert property (
        (wr_hit ##0 (pin_dir_i == 13'h0000)) |=> $stable(pin_out_o))
    else $error("write changed the latch of an input pin");

    a_level_reset_zero: assert property (disable iff (1'b0)
        !rst_n_i |=> ((pin_out_o == 13'h0000) && (event_flag_o == 13'h0000)
                      && (reg_rdata_o[15:13] == 3'h7)))
    else $error("level bits not zero after reset");

    a_read_data_held: assert property (
        no_read |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

    a_flag_sticky: assert property (
        quiet_cycle |=> $stable(event_flag_o))
    else $error("event flag changed with no write or event");

    a_stray_write_ignored: assert property (
        stray_write |=> $stable(pin_out_o))
    else $error("write to another address changed the pin drive");

    a_drive_enable_dir: assert property (
        1'b1 |=> (pin_oe_n_o == ~$past(pin_dir_i)))
    else $error("pad enable does not follow the pin direction");

    a_written_value_read: assert property (
        write_idle_read |=>
            ((reg_rdata_o[12:0] & $past(pin_dir_i)) == ($past(reg_wdata_i[12:0], 3) & $past(pin_dir_i))))
    else $error("read of an output pin does not show the written value");
endmodule // gpio_pin_level_register
`default_nettype wire

/* File: gpio_pin_level_register_tb.sv */
// testbench for the pin level and status register
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_level_register_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [12:0] dir = 13'h0000;
    logic [12:0] ev_set = 13'h0000;
    logic [12:0] ev_flag, pin_in, pin_out, pin_oe_n;
    logic [12:0] ext = 13'h0000;
    int n_fail = 0;
    int comparisons = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    gpio_pin_level_register DUT (.clock_i(clock), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pin_dir_i(dir), .event_set_i(ev_set),
        .event_flag_o(ev_flag), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n));
    pin_far_side far (.ext_level_i(ext), .pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n), .pad_o(pin_in));

    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one write strobe, then an idle cycle
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clock); #1;
        wr = 1'b0;
        @(posedge clock); #1;
    endtask

    // one read strobe, data checked after the read edge
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        addr = a;
        rd = 1'b1;
        @(posedge clock); #1;
        rd = 1'b0;
        check(rdata, exp);
        @(posedge clock); #1;
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog
    initial
    begin
        repeat (3000) @(posedge clock);
        n_fail++;
        wrap_up;
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        @(posedge clock); #1;
        reg_read(8'hE6, 16'hE000);
        check({3'h0, pin_oe_n}, 16'h1FFF);
        check({3'h0, ev_flag}, 16'h0000);
        // walk a single high level across every input pin
        for (int n = 0; n < 13; n++)
        begin
            ext = 13'h0001 << n;
            repeat (3) @(posedge clock); #1;
            reg_read(8'hE6, 16'hE000 | (16'h0001 << n));
        end
        ext = 13'h0000;
        dir = 13'h1F80;
        ev_set = 13'h1FFF;
        @(posedge clock); #1;
        ev_set = 13'h0000;
        check({3'h0, ev_flag}, 16'h1FFF);
        reg_write(8'hE6, 16'h1F7E);
        check({3'h0, ev_flag}, 16'h1FFE);
        check({3'h0, pin_out}, 16'h1F00);
        check({3'h0, pin_oe_n}, 16'h007F);
        check({3'h0, pin_in}, 16'h1F00);
        repeat (3) @(posedge clock); #1;
        reg_read(8'hE6, 16'hFF00);
        reg_write(8'hE6, 16'h0000);
        check({3'h0, ev_flag}, 16'h1F80);
        check({3'h0, pin_out}, 16'h0000);
        reg_write(8'hE7, 16'hFFFF);
        check({3'h0, pin_out}, 16'h0000);
        reg_read(8'hE7, 16'h0000);
        reg_read(8'hE6, 16'hE000);
        // written output value reads back, then a mid-run reset clears it
        reg_write(8'hE6, 16'h1555);
        reg_read(8'hE6, 16'hF500);
        check({3'h0, ev_flag}, 16'h1F80);
        rst_n = 1'b0;
        repeat (2) @(posedge clock); #1;
        check({3'h0, pin_out}, 16'h0000);
        check({3'h0, ev_flag}, 16'h0000);
        check({3'h0, pin_oe_n}, 16'h1FFF);
        check(rdata, 16'hE000);
        rst_n = 1'b1;
        @(posedge clock); #1;
        reg_read(8'hE6, 16'hE000);
        // input pins: written ones keep flag and latch, an event beats a clear
        dir = 13'h0000;
        ev_set = 13'h0010;
        @(posedge clock); #1;
        ev_set = 13'h0000;
        reg_write(8'hE6, 16'h1FFF);
        check({3'h0, ev_flag}, 16'h0010);
        check({3'h0, pin_out}, 16'h0000);
        addr = 8'hE6;
        wdata = 16'h0000;
        wr = 1'b1;
        ev_set = 13'h0010;
        @(posedge clock); #1;
        wr = 1'b0;
        ev_set = 13'h0000;
        @(posedge clock); #1;
        check({3'h0, ev_flag}, 16'h0010);
        reg_write(8'hE6, 16'h1FEF);
        check({3'h0, ev_flag}, 16'h0000);
        wrap_up;
    end
endmodule // gpio_pin_level_register_tb
`default_nettype wire

/* File: pin_far_side.sv */
// far-side pin model: external drivers meeting the pad outputs
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
    input wire logic [12:0] ext_level_i,
    input wire logic [12:0] pin_out_i,
    input wire logic [12:0] pin_oe_n_i,
    output logic [12:0] pad_o
);
    // driven pads show the device value, released pads the external level
    assign pad_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_level_i);
endmodule // pin_far_side
`default_nettype wire

/* File: pin_sync.sv */
// two-stage synchroniser for the pin input levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 13
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            meta <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // pin_sync
`default_nettype wire
